// File: rtl/gdp_pkg.sv
// Shared constants for the general digital I/O port
package gdp_pkg;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_INPUT = 4'h0;
  localparam logic [3:0] OFF_DIR = 4'h4;
  localparam logic [3:0] OFF_DRIVE = 4'h8;
  localparam logic [3:0] OFF_SFIO = 4'hC;
  localparam int PULL_OFF_BIT = 2;
  localparam logic [31:0] RST_DIR = 32'h0000_0000;
  localparam logic [31:0] RST_DRIVE = 32'h0000_0000;
  localparam logic RST_PULL_OFF = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] oldWord,
                                              input logic [31:0] newWord,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newWord[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

// File: rtl/gdp_port.sv
// General digital I/O port with AXI4-Lite register access
// Behaviour
// R1 - Each pin has direction, drive/pull-up and sampled-input bits in separate registers.
// R2 - Direction one makes an output; zero makes an input with driver off.
// R3 - Input pin with drive bit one gets its pull-up; otherwise pull-up off.
// R4 - Output pin drives high for drive bit one, low for zero.
// R5 - Reset tri-states every pin asynchronously, even without a running clock.
// R6 - Global pull-up disable turns off every pull-up in all ports.
// R7 - Input with drive bit clear or pull-ups disabled floats; outputs never pull up.
// R8 - Software passes tri-state/output-high changes through pull-up or output-low state.
// R9 - Software passes pull-up/output-low changes through tri-state or output-high state.
// R10 - Sampled input reflects the pad whatever the direction bit holds.
// R11 - Pad passes a latch open while clock high, then a rising-edge flop.
// R12 - External pin change reaches sampled bit after half to one-and-half periods.
// R13 - A driven value written at an edge is sampled exactly one period later.
// R14 - Software inserts one idle instruction before reading back its written level.
// R15 - Deep-sleep clamp forces each digital input to ground before the buffer.
// R16 - Clamp skips pins with their external interrupt request enabled.
// R17 - Clamped high level on disabled interrupt pin yields an edge at wake.
// R18 - Software pull-ups are off during reset.
// R19 - Write and read strobes are per port; clock, clamp, disable shared by ports.
// R20 - Unused pins should get a defined level, preferably internal pull-up.
// R21 - Input register is read-only; direction and drive registers read and write.
// R22 - Global pull-up disable is bit 2 of the special function register, reset zero.
// R23 - Reset clears direction and drive bits, leaving inputs without pull-up.
module gdp_port #(
  parameter int W = gdp_pkg::PIN_COUNT
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [gdp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gdp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [W-1:0] padIn,
  output logic [W-1:0] padOut,
  output logic [W-1:0] padOe,
  output logic [W-1:0] padPullupEn,
  input wire logic sleepClamp,
  input wire logic [W-1:0] extIntEnable,
  output logic [W-1:0] digitalIn,
  output logic pullupDisable
);

  typedef struct packed {
    logic [gdp_pkg::ADDR_W-1:0] awAddr;
    logic awHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHave;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [W-1:0] dir;
    logic [W-1:0] drive;
    logic pullOff;
    logic [W-1:0] sample;
  } gdp_state_t;

  gdp_state_t st_r;
  gdp_state_t st_nxt;
  logic [W-1:0] syncLatch;
  logic [31:0] wrWord;
  logic [31:0] rdWord;

  assign s_axi_awready = ~st_r.awHave & ~st_r.bValid;
  assign s_axi_wready = ~st_r.wHave & ~st_r.bValid;
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_arready = ~st_r.rValid;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rresp = st_r.rResp;
  assign s_axi_rdata = st_r.rData;

  // Pad controls; reset gates the enables without waiting for an edge
  assign padOe = st_r.dir & {W{~sys_rst}}; // [R2] [R5]
  assign padOut = st_r.drive; // [R4]
  assign padPullupEn = ~st_r.dir & st_r.drive
    & {W{~(st_r.pullOff | sys_rst)}}; // [R3] [R6] [R7] [R18]
  assign pullupDisable = st_r.pullOff; // [R19]

  // Sleep clamp ahead of the input buffer, skipped for enabled interrupt pins
  assign digitalIn = padIn & ~({W{sleepClamp}} & ~extIntEnable); // [R15] [R16] [R17]

  // First synchroniser stage: open while clock high
  always_latch begin
    if (clk_sys) begin
      syncLatch <= digitalIn; // [R11] [R12]
    end
  end

  always_comb begin
    st_nxt = st_r;
    wrWord = 32'h0000_0000;
    rdWord = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.awAddr = s_axi_awaddr;
      st_nxt.awHave = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
      st_nxt.wHave = 1'b1;
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (st_r.awHave && st_r.wHave) begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = gdp_pkg::RESP_OKAY;
      case (st_r.awAddr)
        gdp_pkg::OFF_INPUT: begin
          st_nxt.bResp = gdp_pkg::RESP_OKAY; // [R21]
        end
        gdp_pkg::OFF_DIR: begin
          wrWord[W-1:0] = st_r.dir;
          wrWord = gdp_pkg::merge_bytes(wrWord, st_r.wData, st_r.wStrb);
          st_nxt.dir = wrWord[W-1:0]; // [R1] [R19]
        end
        gdp_pkg::OFF_DRIVE: begin
          wrWord[W-1:0] = st_r.drive;
          wrWord = gdp_pkg::merge_bytes(wrWord, st_r.wData, st_r.wStrb);
          st_nxt.drive = wrWord[W-1:0]; // [R1] [R19]
        end
        gdp_pkg::OFF_SFIO: begin
          wrWord[gdp_pkg::PULL_OFF_BIT] = st_r.pullOff;
          wrWord = gdp_pkg::merge_bytes(wrWord, st_r.wData, st_r.wStrb);
          st_nxt.pullOff = wrWord[gdp_pkg::PULL_OFF_BIT]; // [R22]
        end
        default: begin
          st_nxt.bResp = gdp_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp = gdp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        gdp_pkg::OFF_INPUT: begin
          rdWord[W-1:0] = st_r.sample; // [R10]
        end
        gdp_pkg::OFF_DIR: begin
          rdWord[W-1:0] = st_r.dir; // [R21]
        end
        gdp_pkg::OFF_DRIVE: begin
          rdWord[W-1:0] = st_r.drive; // [R21]
        end
        gdp_pkg::OFF_SFIO: begin
          rdWord[gdp_pkg::PULL_OFF_BIT] = st_r.pullOff;
        end
        default: begin
          st_nxt.rResp = gdp_pkg::RESP_SLVERR;
        end
      endcase
      st_nxt.rData = rdWord;
    end
    // Second synchroniser stage
    st_nxt.sample = syncLatch; // [R11] [R13]
    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.dir = gdp_pkg::RST_DIR[W-1:0]; // [R23]
      st_nxt.drive = gdp_pkg::RST_DRIVE[W-1:0]; // [R23]
      st_nxt.pullOff = gdp_pkg::RST_PULL_OFF; // [R22]
    end
  end

  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  property p_oe_follows_dir;
    @(posedge clk_sys) disable iff (sys_rst) !sys_rst |-> (padOe == st_r.dir);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) // [R2]
    else $error("output enable differs from direction bits");

  property p_reset_tristate;
    @(posedge clk_sys) sys_rst |-> (padOe == '0) && (padPullupEn == '0);
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) // [R5]
    else $error("pin driven or pulled up during reset");

  property p_pullup_on;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_r.drive[0] && !st_r.dir[0] && !st_r.pullOff) |-> padPullupEn[0];
  endproperty
  a_pullup_on: assert property (p_pullup_on) // [R3]
    else $error("pull-up missing on input with drive bit set");

  property p_pull_off_all;
    @(posedge clk_sys) disable iff (sys_rst) pullupDisable |-> (padPullupEn == '0);
  endproperty
  a_pull_off_all: assert property (p_pull_off_all) // [R6]
    else $error("pull-up active while globally disabled");

  property p_output_no_pullup;
    @(posedge clk_sys) disable iff (sys_rst) (padOe & padPullupEn) == '0;
  endproperty
  a_output_no_pullup: assert property (p_output_no_pullup) // [R7]
    else $error("output pin has pull-up enabled");

  property p_drive_value;
    @(posedge clk_sys) disable iff (sys_rst) padOe[0] |-> (padOut[0] == st_r.drive[0]);
  endproperty
  a_drive_value: assert property (p_drive_value) // [R4]
    else $error("driven level differs from drive bit");

  property p_clamp;
    @(posedge clk_sys) disable iff (sys_rst)
      (sleepClamp && !extIntEnable[0]) |-> !digitalIn[0];
  endproperty
  a_clamp: assert property (p_clamp) // [R15]
    else $error("clamped input not grounded");

  property p_clamp_skip;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sleepClamp || extIntEnable[0]) |-> (digitalIn[0] == padIn[0]);
  endproperty
  a_clamp_skip: assert property (p_clamp_skip) // [R16]
    else $error("unclamped input differs from pad");

  property p_input_ro;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_r.awHave && st_r.wHave && st_r.awAddr == gdp_pkg::OFF_INPUT)
      |=> (st_r.dir == $past(st_r.dir)) && (st_r.drive == $past(st_r.drive));
  endproperty
  a_input_ro: assert property (p_input_ro) // [R21]
    else $error("write to input register changed state");

  property p_reset_clear;
    @(posedge clk_sys) sys_rst |=> (st_r.dir == '0) && (st_r.drive == '0) && !st_r.pullOff;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [R23]
    else $error("registers not cleared by reset");

  property p_bvalid_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) // [R19]
    else $error("write response dropped before accepted");

  property p_float_pin;
    @(posedge clk_sys) disable iff (sys_rst)
      (!st_r.dir[0] && (!st_r.drive[0] || st_r.pullOff)) |-> !padOe[0] && !padPullupEn[0];
  endproperty
  a_float_pin: assert property (p_float_pin) // [R7]
    else $error("floating input is driven or pulled up");

  property p_sample_changed;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sys_rst && $changed(digitalIn)) ##1 (!sys_rst && $stable(digitalIn))
      |=> (st_r.sample == $past(digitalIn));
  endproperty
  a_sample_changed: assert property (p_sample_changed) // [R12]
    else $error("pin change not sampled within one and a half periods");

  property p_sample_steady;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sys_rst && $stable(digitalIn)) |=> (st_r.sample == $past(digitalIn));
  endproperty
  a_sample_steady: assert property (p_sample_steady) // [R13]
    else $error("steady pin level not sampled after one period");

  property p_dir_readback;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sys_rst && s_axi_arvalid && s_axi_arready && s_axi_araddr == gdp_pkg::OFF_DIR)
      |=> (s_axi_rdata == 32'($past(st_r.dir)));
  endproperty
  a_dir_readback: assert property (p_dir_readback) // [R21]
    else $error("direction read returned a different word");

  property p_pull_off_read;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sys_rst && s_axi_arvalid && s_axi_arready && s_axi_araddr == gdp_pkg::OFF_SFIO)
      |=> (s_axi_rdata == (32'($past(st_r.pullOff)) << gdp_pkg::PULL_OFF_BIT));
  endproperty
  a_pull_off_read: assert property (p_pull_off_read) // [R22]
    else $error("special function read returned a different word");

  property p_drive_write;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sys_rst && st_r.awHave && st_r.wHave && st_r.awAddr == gdp_pkg::OFF_DRIVE
        && st_r.wStrb == 4'hF) |=> (st_r.drive == $past(st_r.wData[W-1:0]));
  endproperty
  a_drive_write: assert property (p_drive_write) // [R1]
    else $error("full write to drive register did not land");

  property p_dir_write;
    @(posedge clk_sys) disable iff (sys_rst)
      (!sys_rst && st_r.awHave && st_r.wHave && st_r.awAddr == gdp_pkg::OFF_DIR
        && st_r.wStrb == 4'hF) |=> (st_r.dir == $past(st_r.wData[W-1:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) // [R1]
    else $error("full write to direction register did not land");

endmodule // gdp_port

// File: tb/gdp_pad_model.sv
// Board-side pad model for the digital I/O port
module gdp_pad_model #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic [W-1:0] padOut,
  input wire logic [W-1:0] padOe,
  input wire logic [W-1:0] padPullupEn,
  input wire logic [W-1:0] extDrv,
  input wire logic [W-1:0] extDrvEn,
  output logic [W-1:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] floatPat = '0;
  // Undriven pads wander every cycle
  always @(posedge clk_sys) floatPat <= ~floatPat;
  // Device drive wins, then board driver, then pull-up level
  assign padIn = (padOe & padOut) | (~padOe & extDrvEn & extDrv)
    | (~padOe & ~extDrvEn & (padPullupEn | floatPat));
endmodule // gdp_pad_model

// File: tb/tb.sv
// Self-checking bench for the digital I/O port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] dir, drv; logic poff; logic [7:0] oe, pu, in;} gdp_row_t;
  logic clk_sys = 1'h0, sys_rst = 1'h1, sleepClamp = 1'h0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pullupDisable;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] padIn, padOut, padOe, padPullupEn, digitalIn, extIntEnable = '0;
  logic [7:0] extDrv = 8'h5A, extDrvEn = 8'hFF;
  int n_errors = 0, compares = 0;
  gdp_row_t rows [6] = '{
    '{8'h00, 8'h00, 1'h0, 8'h00, 8'h00, 8'h5A},
    '{8'h00, 8'hFF, 1'h0, 8'h00, 8'hFF, 8'h5A},
    '{8'h00, 8'hFF, 1'h1, 8'h00, 8'h00, 8'h5A},
    '{8'hFF, 8'hFF, 1'h0, 8'hFF, 8'h00, 8'hFF},
    '{8'hFF, 8'h00, 1'h0, 8'hFF, 8'h00, 8'h00},
    '{8'h00, 8'h00, 1'h0, 8'h00, 8'h00, 8'h5A}};

  gdp_port dut (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .padIn, .padOut, .padOe, .padPullupEn, .sleepClamp,
    .extIntEnable, .digitalIn, .pullupDisable);
  gdp_pad_model #(.W(8)) board (.clk_sys, .padOut, .padOe, .padPullupEn, .extDrv, .extDrvEn,
    .padIn);

  initial forever #4 clk_sys = ~clk_sys;

  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) s_axi_bready <= 1'h1;
    end while (s_axi_bvalid !== 1'h1 || s_axi_bready !== 1'h1);
    rs = s_axi_bresp;
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  initial begin
    #100000;
    n_errors++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    chk(padOe, 32'h0);
    chk(padPullupEn, 32'h0);
    sys_rst <= 1'h0;
    for (int i = 4; i < 16; i += 4) begin
      axr(4'(i));
      chk(d, 32'h0);
    end
    // Drive before direction keeps each step a legal pair except rows[2] to rows[3], tri-state to output high
    foreach (rows[i]) begin
      axw(gdp_pkg::OFF_DRIVE, 32'(rows[i].drv));
      axw(gdp_pkg::OFF_DIR, 32'(rows[i].dir));
      axw(gdp_pkg::OFF_SFIO, {29'h0, rows[i].poff, 2'h0});
      repeat (3) @(posedge clk_sys);
      #1;
      chk(padOe, rows[i].oe);
      chk(padPullupEn, rows[i].pu);
      chk(padOut & rows[i].oe, rows[i].drv & rows[i].oe);
      chk(pullupDisable, rows[i].poff);
      axr(gdp_pkg::OFF_INPUT);
      chk(d, rows[i].in);
      axr(gdp_pkg::OFF_DIR);
      chk(d, rows[i].dir);
    end
    axw(gdp_pkg::OFF_INPUT, 32'hFF);
    chk(rs, gdp_pkg::RESP_OKAY);
    axr(gdp_pkg::OFF_INPUT);
    chk(d, 32'h5A);
    axr(4'h2);
    chk(rs, gdp_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    axw(4'h6, 32'h1);
    chk(rs, gdp_pkg::RESP_SLVERR);
    // Deep sleep with interrupts on the low nibble
    sleepClamp <= 1'h1;
    extIntEnable <= 8'h0F;
    @(posedge clk_sys);
    #1;
    chk(digitalIn, 32'h0A);
    repeat (2) @(posedge clk_sys);
    axr(gdp_pkg::OFF_INPUT);
    chk(d, 32'h0A);
    @(posedge clk_sys);
    sleepClamp <= 1'h0;
    #1;
    chk(digitalIn, 32'h5A);
    axw(gdp_pkg::OFF_DIR, 32'hFF);
    axw(gdp_pkg::OFF_DRIVE, 32'hC3);
    @(posedge clk_sys);
    axr(gdp_pkg::OFF_INPUT);
    chk(d, 32'hC3);
    axw(gdp_pkg::OFF_DRIVE, 32'hFF);
    axw(gdp_pkg::OFF_DIR, 32'h0F);
    chk(padPullupEn, 32'hF0);
    // Reset in mid-run must float pads at once
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    #1;
    chk(padOe, 32'h0);
    chk(padPullupEn, 32'h0);
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    axr(gdp_pkg::OFF_DIR);
    chk(d, 32'h0);
    // Held write response, then pull-ups seen on undriven pads
    s_axi_bready <= 1'h0;
    axw(gdp_pkg::OFF_DRIVE, 32'hF0);
    chk(rs, gdp_pkg::RESP_OKAY);
    extDrvEn <= 8'h0F;
    repeat (2) @(posedge clk_sys);
    axr(gdp_pkg::OFF_INPUT);
    chk(d, 32'hFA);
    axr(gdp_pkg::OFF_DRIVE);
    chk(d, 32'hF0);
    close_out;
  end
endmodule // tb
